/* src/port_status_cfg.svh */
// Command codes, field positions, reset values and timing constants for the root hub port registers.
`ifndef PORT_STATUS_CFG_SVH
`define PORT_STATUS_CFG_SVH

`define CMD_RD_PORT1 8'h15
`define CMD_RD_PORT2 8'h16
`define CMD_WR_PORT1 8'h95
`define CMD_WR_PORT2 8'h96

`define BIT_CONNECTED 0
`define BIT_ENABLED 1
`define BIT_SUSPENDED 2
`define BIT_OVERCURRENT 3
`define BIT_RESET_ACTIVE 4
`define BIT_POWER_ON 8
`define BIT_LOW_SPEED 9
`define BIT_CONNECT_CHG 16
`define BIT_ENABLE_CHG 17
`define BIT_RESUME_DONE_CHG 18
`define BIT_OVERCURRENT_CHG 19
`define BIT_RESET_DONE_CHG 20

`define PORT_RESET_VALUE 32'h0000_0000

`define CLK_FREQ_HZ 20000000
`define PORT_RESET_MS 10
`define RESYNC_MS 3
`define PORT_RESET_CYCLES ((`PORT_RESET_MS * `CLK_FREQ_HZ) / 1000)
`define RESYNC_CYCLES ((`RESYNC_MS * `CLK_FREQ_HZ) / 1000)

`endif

/* src/port_status_pkg.sv */
// Types shared by the root hub port status and change logic.
package port_status_pkg;

    // Status half of one port register.
    typedef struct packed {
        logic low_speed_attached;
        logic port_power_on;
        logic port_reset_active;
        logic port_overcurrent;
        logic port_suspended;
        logic port_enabled;
        logic device_connected;
    } port_stat_s;

    // Sticky change half of one port register.
    typedef struct packed {
        logic reset_done_chg;
        logic overcurrent_chg;
        logic resume_done_chg;
        logic enable_chg;
        logic connect_chg;
    } port_chg_s;

    // Events reported by the port signalling logic for one port.
    typedef struct packed {
        logic connected;
        logic low_speed;
        logic overcurrent;
        logic enable_lost;
        logic resume_signal_done;
    } port_evt_s;

    // Write strobes handed from the register file to the port signalling logic.
    typedef struct packed {
        logic set_reset;
        logic set_enable;
        logic clr_enable;
        logic set_suspend;
        logic clr_suspend;
        logic set_power;
        logic clr_power;
    } port_req_s;

    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_RESET = 2'b01,
        PH_RESYNC = 2'b10
    } phase_e;

    typedef struct packed {
        port_stat_s stat;
        port_chg_s chg;
        phase_e phase;
        logic [31:0] count;
        logic pend_valid;
        logic [31:0] pend_data;
        logic oc_seen;
        logic conn_seen;
    } port_state_s;

    typedef struct packed {
        port_state_s [1:0] port;
        logic [31:0] rd_data;
        logic rd_valid;
    } block_state_s;

endpackage

/* src/root_hub_port_status_change.sv */
// Status and sticky change registers for the two downstream root hub ports.
`include "port_status_cfg.svh"
// What this block does
// - Defer status writes until transaction completes.
// - Status low half, change flags high half.
// - One register per downstream port, two.
// - Codes 15h and 16h read ports.
// - Codes 95h and 96h write ports.
// - Reset done flag set after reset.
// - Writing one clears change flag; zero ignored.
// - Overcurrent change set on indicator change.
// - Resume done set after full sequence.
// - Resume done cleared when reset done sets.
// - Enable change set on hardware disable.
// - Software enable changes never set flag.
// - Connect change set on connect/disconnect.
// - Overcurrent clears port power.
// - Bit 9 reports low-speed device.
module root_hub_port_status_change #(
    parameter int PORTS = 2,
    parameter int RESET_CYCLES = `PORT_RESET_CYCLES,
    parameter int RESYNC_CYCLES = `RESYNC_CYCLES
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst,
    // Command bus.
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic [31:0] cmd_wdata,
    output logic [31:0] rd_data,
    output logic rd_valid,
    // USB transaction in progress, token through handshake.
    input wire logic usb_busy,
    // Port events from the signalling logic.
    input port_status_pkg::port_evt_s [1:0] port_evt,
    // Port status and change flags toward the signalling logic.
    output port_status_pkg::port_stat_s [1:0] port_stat,
    output port_status_pkg::port_chg_s [1:0] port_chg
);

    // The decoder only knows two command codes per direction.
    initial begin
        if (PORTS != 2) begin
            $error("root_hub_port_status_change supports exactly two ports");
        end
        if (RESET_CYCLES < 1 || RESYNC_CYCLES < 1) begin
            $error("timing counts must be at least one cycle");
        end
    end

    port_status_pkg::block_state_s st_ff;
    port_status_pkg::block_state_s nxt_st;

    // Compose a register image: status in the low half, changes in the high half.
    function automatic logic [31:0] image(input port_status_pkg::port_state_s p);
        logic [31:0] v;
        v = `PORT_RESET_VALUE;
        v[`BIT_CONNECTED] = p.stat.device_connected;
        v[`BIT_ENABLED] = p.stat.port_enabled;
        v[`BIT_SUSPENDED] = p.stat.port_suspended;
        v[`BIT_OVERCURRENT] = p.stat.port_overcurrent;
        v[`BIT_RESET_ACTIVE] = p.stat.port_reset_active;
        v[`BIT_POWER_ON] = p.stat.port_power_on;
        v[`BIT_LOW_SPEED] = p.stat.device_connected & p.stat.low_speed_attached;
        v[`BIT_CONNECT_CHG] = p.chg.connect_chg;
        v[`BIT_ENABLE_CHG] = p.chg.enable_chg;
        v[`BIT_RESUME_DONE_CHG] = p.chg.resume_done_chg;
        v[`BIT_OVERCURRENT_CHG] = p.chg.overcurrent_chg;
        v[`BIT_RESET_DONE_CHG] = p.chg.reset_done_chg;
        return v;
    endfunction

    // Next state: command decode, deferred writes, hardware events and timers.
    always_comb begin
        logic [31:0] w;
        logic apply;
        logic rst_done;
        logic resume_done;
        logic hw_disable;
        logic conn_evt;
        w = '0;
        apply = 1'b0;
        rst_done = 1'b0;
        resume_done = 1'b0;
        hw_disable = 1'b0;
        conn_evt = 1'b0;
        nxt_st = st_ff;
        nxt_st.rd_valid = 1'b0;
        if (cmd_valid) begin
            case (cmd_code)
                `CMD_RD_PORT1: begin
                    nxt_st.rd_data = image(st_ff.port[0]);
                    nxt_st.rd_valid = 1'b1;
                end
                `CMD_RD_PORT2: begin
                    nxt_st.rd_data = image(st_ff.port[1]);
                    nxt_st.rd_valid = 1'b1;
                end
                `CMD_WR_PORT1: begin
                    nxt_st.port[0].pend_valid = 1'b1;
                    nxt_st.port[0].pend_data = cmd_wdata;
                end
                `CMD_WR_PORT2: begin
                    nxt_st.port[1].pend_valid = 1'b1;
                    nxt_st.port[1].pend_data = cmd_wdata;
                end
                default: begin
                end
            endcase
        end
        for (int i = 0; i < 2; i++) begin
            w = st_ff.port[i].pend_data;
            // A write waits while a transaction is on the bus.
            apply = st_ff.port[i].pend_valid && !usb_busy;
            rst_done = 1'b0;
            resume_done = 1'b0;
            hw_disable = 1'b0;
            if (apply) begin
                nxt_st.port[i].pend_valid = cmd_valid && (cmd_code == (i == 0 ? `CMD_WR_PORT1 : `CMD_WR_PORT2));
                // Change flags clear on one; a later event in this cycle sets again.
                if (w[`BIT_CONNECT_CHG]) nxt_st.port[i].chg.connect_chg = 1'b0;
                if (w[`BIT_ENABLE_CHG]) nxt_st.port[i].chg.enable_chg = 1'b0;
                if (w[`BIT_RESUME_DONE_CHG]) nxt_st.port[i].chg.resume_done_chg = 1'b0;
                if (w[`BIT_OVERCURRENT_CHG]) nxt_st.port[i].chg.overcurrent_chg = 1'b0;
                if (w[`BIT_RESET_DONE_CHG]) nxt_st.port[i].chg.reset_done_chg = 1'b0;
                // Low half on write: 0 clear enable, 1 set enable, 2 set suspend, 3 clear suspend,
                // 4 set reset, 8 set power, 9 clear power. Software enable changes are silent.
                if (w[0]) nxt_st.port[i].stat.port_enabled = 1'b0;
                if (w[1] && st_ff.port[i].stat.device_connected) nxt_st.port[i].stat.port_enabled = 1'b1;
                if (w[2] && st_ff.port[i].stat.device_connected) nxt_st.port[i].stat.port_suspended = 1'b1;
                if (w[3] && st_ff.port[i].stat.port_suspended) begin
                    nxt_st.port[i].phase = port_status_pkg::PH_RESYNC;
                    nxt_st.port[i].count = '0;
                end
                if (w[4] && st_ff.port[i].stat.device_connected) begin
                    nxt_st.port[i].stat.port_reset_active = 1'b1;
                    nxt_st.port[i].phase = port_status_pkg::PH_RESET;
                    nxt_st.port[i].count = '0;
                end
                if ((w[1] | w[2] | w[4]) && !st_ff.port[i].stat.device_connected) conn_evt = 1'b1;
                if (w[8]) nxt_st.port[i].stat.port_power_on = 1'b1;
                if (w[9]) nxt_st.port[i].stat.port_power_on = 1'b0;
            end
            // Reset signalling and resume resync timers.
            case (st_ff.port[i].phase)
                port_status_pkg::PH_RESET: begin
                    nxt_st.port[i].count = st_ff.port[i].count + 32'h0000_0001;
                    if (st_ff.port[i].count == 32'(RESET_CYCLES - 1)) begin
                        rst_done = 1'b1;
                        nxt_st.port[i].phase = port_status_pkg::PH_IDLE;
                        nxt_st.port[i].stat.port_reset_active = 1'b0;
                        nxt_st.port[i].stat.port_enabled = 1'b1;
                    end
                end
                port_status_pkg::PH_RESYNC: begin
                    // Counting starts once the resume pulse and low-speed end of packet are done.
                    if (port_evt[i].resume_signal_done || st_ff.port[i].count != '0) begin
                        nxt_st.port[i].count = st_ff.port[i].count + 32'h0000_0001;
                    end
                    if (st_ff.port[i].count == 32'(RESYNC_CYCLES)) begin
                        resume_done = 1'b1;
                        nxt_st.port[i].phase = port_status_pkg::PH_IDLE;
                        nxt_st.port[i].stat.port_suspended = 1'b0;
                    end
                end
                default: begin
                    nxt_st.port[i].count = '0;
                end
            endcase
            // Overcurrent indicator follows the pin and drops port power.
            nxt_st.port[i].oc_seen = port_evt[i].overcurrent;
            nxt_st.port[i].stat.port_overcurrent = port_evt[i].overcurrent;
            if (port_evt[i].overcurrent) nxt_st.port[i].stat.port_power_on = 1'b0;
            if (port_evt[i].overcurrent != st_ff.port[i].oc_seen) nxt_st.port[i].chg.overcurrent_chg = 1'b1;
            // Connect tracking.
            nxt_st.port[i].conn_seen = port_evt[i].connected;
            nxt_st.port[i].stat.device_connected = port_evt[i].connected;
            nxt_st.port[i].stat.low_speed_attached = port_evt[i].low_speed;
            if (port_evt[i].connected != st_ff.port[i].conn_seen || conn_evt) begin
                nxt_st.port[i].chg.connect_chg = 1'b1;
            end
            conn_evt = 1'b0;
            // Hardware disable: lost enable, disconnect or overcurrent.
            hw_disable = st_ff.port[i].stat.port_enabled &&
                (port_evt[i].enable_lost || !port_evt[i].connected || port_evt[i].overcurrent);
            if (hw_disable) begin
                nxt_st.port[i].stat.port_enabled = 1'b0;
                nxt_st.port[i].chg.enable_chg = 1'b1;
            end
            if (resume_done) nxt_st.port[i].chg.resume_done_chg = 1'b1;
            if (rst_done) begin
                nxt_st.port[i].chg.reset_done_chg = 1'b1;
                nxt_st.port[i].chg.resume_done_chg = 1'b0;
            end
        end
    end

    // State register; everything starts cleared.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs come straight from the state register.
    assign rd_data = st_ff.rd_data;
    assign rd_valid = st_ff.rd_valid;
    assign port_stat[0] = st_ff.port[0].stat;
    assign port_stat[1] = st_ff.port[1].stat;
    assign port_chg[0] = st_ff.port[0].chg;
    assign port_chg[1] = st_ff.port[1].chg;

endmodule

/* sim/usb_port_dev.sv */
// Behavioural model of the devices attached to the two downstream ports.
module usb_port_dev (
    // Clock.
    input wire logic mclk,
    // Port events toward the block.
    output port_status_pkg::port_evt_s [1:0] port_evt
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // Attach, detach and event signalling
    // ------------------------------------------------------------
    // Nothing is attached at power up.
    initial port_evt = '0;

    // Levels change just after an edge, so a pulse is two calls one cycle apart.
    task automatic set_evt(input int p, input port_status_pkg::port_evt_s v);
        @(posedge mclk);
        port_evt[p] <= v;
    endtask
endmodule

/* sim/port_status_monitor.sv */
// Concurrent checks on the ports of the root hub port status block.
module port_status_monitor #(
    parameter int PORTS = 2,
    parameter int RESET_CYCLES = 8,
    parameter int RESYNC_CYCLES = 5
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst,
    // Command bus.
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic [31:0] cmd_wdata,
    input wire logic [31:0] rd_data,
    input wire logic rd_valid,
    input wire logic usb_busy,
    // Port side.
    input port_status_pkg::port_evt_s [1:0] port_evt,
    input port_status_pkg::port_stat_s [1:0] port_stat,
    input port_status_pkg::port_chg_s [1:0] port_chg
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_read_answer: assert property (cmd_valid && cmd_code inside {8'h15, 8'h16} |=> rd_valid)
        else $error("read command not answered");
    a_no_stray_read: assert property (!(cmd_valid && cmd_code inside {8'h15, 8'h16}) |=> !rd_valid)
        else $error("read answer without read command");
    a_port1_image: assert property (cmd_valid && cmd_code == 8'h15 |=>
        rd_data[31:10] == {11'h0, $past(port_chg[0]), 6'h0} &&
        rd_data[8:0] == {$past(port_stat[0].port_power_on), 3'h0, $past(port_stat[0][4:0])})
        else $error("port 1 read image wrong");
    a_port2_image: assert property (cmd_valid && cmd_code == 8'h16 |=>
        rd_data[31:16] == {11'h0, $past(port_chg[1])})
        else $error("port 2 change half wrong");
    a_flags_clear: assert property ($fell(rst) |-> port_chg == '0 && port_stat == '0)
        else $error("flags not clear after reset");
    a_resume_cleared: assert property ($rose(port_chg[1].reset_done_chg) |-> !port_chg[1].resume_done_chg)
        else $error("resume flag kept when reset flag set");
    a_reset_done: assert property ($fell(port_stat[0].port_reset_active) |-> ##[0:1] port_chg[0].reset_done_chg)
        else $error("reset end without reset flag");
    a_oc_change: assert property ($changed(port_stat[0].port_overcurrent) |-> ##[0:1] port_chg[0].overcurrent_chg)
        else $error("overcurrent change not flagged");
    a_oc_power: assert property ($rose(port_stat[0].port_overcurrent) |-> ##[0:1] !port_stat[0].port_power_on)
        else $error("power kept on overcurrent");
    a_hw_enable_chg: assert property ($rose(port_chg[0].enable_chg) |-> $fell(port_stat[0].port_enabled))
        else $error("enable flag set without enable loss");
    a_write_deferred: assert property (usb_busy && cmd_valid && cmd_code == 8'h95 |=>
        $stable(port_stat[0].port_enabled))
        else $error("write applied during transaction");

    // Main scenarios reached.
    c_read: cover property (rd_valid);
    c_reset_done: cover property ($rose(port_chg[0].reset_done_chg));
    c_deferred: cover property (usb_busy && cmd_valid);
endmodule

bind root_hub_port_status_change port_status_monitor #(.PORTS(PORTS), .RESET_CYCLES(RESET_CYCLES),
    .RESYNC_CYCLES(RESYNC_CYCLES)) mon (.mclk(mclk), .rst(rst), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata), .rd_data(rd_data), .rd_valid(rd_valid), .usb_busy(usb_busy), .port_evt(port_evt),
    .port_stat(port_stat), .port_chg(port_chg));

/* sim/root_hub_port_status_change_tb.sv */
// Self-checking testbench for the root hub port status and change registers.
module root_hub_port_status_change_tb;
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // Stimulus and checking
    // ------------------------------------------------------------
    logic mclk;
    logic rst;
    logic cmd_valid;
    logic [7:0] cmd_code;
    logic [31:0] cmd_wdata;
    logic [31:0] rd_data;
    logic rd_valid;
    logic usb_busy;
    port_status_pkg::port_evt_s [1:0] port_evt;
    port_status_pkg::port_stat_s [1:0] port_stat;
    port_status_pkg::port_chg_s [1:0] port_chg;
    logic [63:0] exp_q[$];
    logic [63:0] note;
    int mismatches = 0;
    int compares = 0;

    root_hub_port_status_change #(.PORTS(2), .RESET_CYCLES(8), .RESYNC_CYCLES(5)) dut (.mclk(mclk), .rst(rst),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rd_data(rd_data),
        .rd_valid(rd_valid), .usb_busy(usb_busy), .port_evt(port_evt), .port_stat(port_stat),
        .port_chg(port_chg));
    usb_port_dev dev (.mclk(mclk), .port_evt(port_evt));

    // The 20 MHz clock.
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %0s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Commands are one-cycle strobes; an edge always passes between two of them.
    task automatic cmd(input logic [7:0] code, input logic [31:0] data);
        @(posedge mclk);
        cmd_valid <= 1'b1;
        cmd_code <= code;
        cmd_wdata <= data;
        @(posedge mclk);
        cmd_valid <= 1'b0;
    endtask

    task automatic rd(input int p, input logic [31:0] exp, input logic [31:0] mask = 32'hffff_ffff);
        exp_q.push_back({mask, exp});
        cmd(p != 0 ? 8'h16 : 8'h15, 32'h0);
    endtask

    task automatic wr(input int p, input logic [31:0] data);
        cmd(p != 0 ? 8'h96 : 8'h95, data);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic done(input string name);
        $display("test %0s done", name);
    endtask

    task automatic print_verdict();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Each read answer is compared, masked, with the oldest noted expectation.
    always @(posedge mclk) begin
        if (rd_valid === 1'b1) begin
            note = exp_q.pop_front();
            check("rd_data", rd_data & note[63:32], note[31:0]);
        end
    end

    // Cuts a hung run short; the tests need well under 500 cycles.
    initial begin
        repeat (4000) @(posedge mclk);
        mismatches++;
        print_verdict();
    end

    // Main sequence; reserved bits are always written as zero.
    initial begin
        rst = 1'b1;
        cmd_valid = 1'b0;
        cmd_code = 8'h00;
        cmd_wdata = 32'h0;
        usb_busy = 1'b0;
        void'($urandom(32'hd2d34520));
        cyc(20);
        rst <= 1'b0;
        rd(0, 32'h0);
        rd(1, 32'h0);
        cmd(8'h20 + 8'($urandom_range(0, 8'h5f)), $urandom & 32'h001f_031f);
        rd(0, 32'h0);
        wr(1, 32'h2);
        rd(1, 32'h0001_0000);
        wr(1, 32'h0001_0000);
        rd(1, 32'h0);
        done("reset");
        dev.set_evt(0, 5'b11000);
        cyc(4);
        rd(0, 32'h0001_0201);
        wr(0, 32'h0);
        rd(0, 32'h0001_0201);
        wr(0, 32'h0001_0000);
        rd(0, 32'h0000_0201);
        wr(0, 32'h0000_0102);
        rd(0, 32'h0000_0303);
        done("connect");
        usb_busy <= 1'b1;
        wr(0, 32'h1);
        cyc(4);
        rd(0, 32'h0000_0303);
        usb_busy <= 1'b0;
        cyc(3);
        rd(0, 32'h0000_0301);
        done("defer");
        wr(0, 32'h2);
        wr(0, 32'h10);
        cyc(12);
        rd(0, 32'h0010_0303);
        wr(0, 32'h0010_0000);
        dev.set_evt(0, 5'b11010);
        dev.set_evt(0, 5'b11000);
        cyc(4);
        rd(0, 32'h0002_0301);
        dev.set_evt(0, 5'b11100);
        cyc(4);
        rd(0, 32'h000a_0209);
        wr(0, 32'h000a_0000);
        dev.set_evt(0, 5'b11000);
        cyc(4);
        rd(0, 32'h0008_0201);
        done("port events");
        dev.set_evt(1, 5'b10000);
        cyc(4);
        wr(1, 32'h0001_0102);
        wr(1, 32'h4);
        wr(1, 32'h8);
        dev.set_evt(1, 5'b10001);
        dev.set_evt(1, 5'b10000);
        rd(1, 32'h0, 32'h0004_0000);
        cyc(8);
        rd(1, 32'h0004_0000, 32'h001f_0000);
        wr(1, 32'h10);
        cyc(12);
        rd(1, 32'h0010_0000, 32'h001f_0000);
        wr(1, 32'h200);
        cyc(4);
        check("port2 stat", 32'(port_stat[1]), 32'h3);
        check("port2 chg", 32'(port_chg[1]), 32'h10);
        done("resume");
        cyc(4);
        check("pending reads", 32'(exp_q.size()), 32'h0);
        print_verdict();
    end
endmodule
